// file: logic/ldp_pkg.sv
package ldp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam int PULSE_NOM_MS = 200;
  localparam int PULSE_MIN_MS = 100;
  localparam int STROBE_HI_US = 1000;
  localparam int STROBE_LO_US = 1000;
  localparam int PULSE_MIN_CYC = int'((PULSE_MIN_MS * CLK_HZ + 999) / 1000);
  localparam int STROBE_HI_CYC = int'((STROBE_HI_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int STROBE_LO_CYC = int'((STROBE_LO_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_EVENT = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_READING = 8'h08;
  localparam logic [7:0] REG_SETPOINT = 8'h0c;
  localparam logic [7:0] REG_DEVCTL = 8'h10;
  localparam logic [7:0] REG_DEVSTAT = 8'h14;
  localparam logic [7:0] REG_SERCMD = 8'h18;

  // ----------------------------------------------------------------
  // Input indices, also event bit positions for the pulse inputs
  // ----------------------------------------------------------------
  localparam int IN_START = 0;
  localparam int IN_STOP = 1;
  localparam int IN_ZERO = 2;
  localparam int IN_TUNE = 3;
  localparam int IN_DOWN = 4;
  localparam int IN_UP = 5;
  localparam int IN_GATE = 6;
  localparam int IN_SCALE = 7;
  localparam int NUM_PULSE = 6;
  localparam int NUM_IN = 8;
  localparam int EV_SER_OK = 6;
  localparam int EV_SER_NAK = 7;
  localparam int EV_W = 8;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DC_FIL = 0;
  localparam int DC_NRDY = 1;
  localparam int DC_ZDONE = 2;
  localparam int DC_CDONE = 3;
  localparam int DC_CPASS = 4;
  localparam int DS_GATE = 0;
  localparam int DS_SCALE = 1;
  localparam int DS_ZEROING = 2;
  localparam int DS_CAL = 3;
  localparam int DS_CALOK = 4;
  localparam int DS_REJECT = 5;
  localparam int DS_STROBE = 6;
  localparam int RD_OVER = 16;
  localparam logic [6:0] EXP_MAX = 7'd99;
  localparam logic [6:0] EXP_RST = 7'd0;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] SETPOINT_RST = 16'h6399;

  // Serial command codes
  localparam logic [1:0] SER_CAL = 2'h0;
  localparam logic [1:0] SER_FPEAK = 2'h1;
  localparam logic [1:0] SER_TUNE = 2'h2;
  localparam logic [1:0] SER_ZERO = 2'h3;

  // Two BCD digits, weights 1, 2, 4, 8 on lines A to D
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } ldp_bcd2_s;

  // Binary 0..99 to two BCD digits
  function automatic ldp_bcd2_s ldp_to_bcd(input logic [6:0] v);
    ldp_bcd2_s r;
    r.hi = 4'(v / 7'd10);
    r.lo = 4'(v % 7'd10);
    return r;
  endfunction

endpackage

// file: logic/ldp_plc_port.sv
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns

module ldp_plc_port #(
  parameter int unsigned QUAL_CYC = ldp_pkg::PULSE_MIN_CYC,
  parameter int unsigned STROBE_HI = ldp_pkg::STROBE_HI_CYC,
  parameter int unsigned STROBE_LO = ldp_pkg::STROBE_LO_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Discrete control connector
  input wire logic START,
  input wire logic STOP,
  input wire logic GATE,
  input wire logic ZERO,
  input wire logic TUNE_REQ,
  input wire logic SCALE_DN,
  input wire logic SCALE_UP,
  input wire logic SELF_SCALE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Status outputs
  output logic REJECT,
  output logic FIL_FAULT,
  output logic NOT_READY,
  output logic READY,
  output logic CAL_OK,
  output logic ZEROING,
  output logic CALIBRATING,
  // Digit output connector
  output logic UPDATE_STROBE,
  output ldp_pkg::ldp_bcd2_s MANT,
  output ldp_pkg::ldp_bcd2_s EXPN,
  // Sequencer requests and interrupt
  output logic SEQ_START,
  output logic SEQ_VENT,
  output logic IRQ
);
  import ldp_pkg::*;

  typedef enum logic [1:0] {ST_HOLD, ST_WAIT, ST_HIGH} ldp_strobe_e;

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] pins;
  logic [NUM_IN-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [NUM_PULSE-1:0] cmd_q;
  logic [CNT_W-1:0] qcnt_q [NUM_PULSE];
  logic gate_f, auto_f;

  assign pins = {SELF_SCALE, GATE, SCALE_UP, SCALE_DN, TUNE_REQ, ZERO, STOP, START};
  assign gate_f = filt_q[IN_GATE];
  assign auto_f = filt_q[IN_SCALE] & gate_f;

  genvar gi;
  generate
    // Three-stage sync; level changes once stages two and three agree
    for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pins[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
    // Pulse qualifier: fires once when held high long enough, gated
    for (gi = 0; gi < NUM_PULSE; gi++) begin : g_qual
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          qcnt_q[gi] <= '0;
          cmd_q[gi] <= 1'b0;
        end else begin
          cmd_q[gi] <= filt_q[gi] && gate_f
                       && (qcnt_q[gi] == CNT_W'(QUAL_CYC - 1));
          if (!filt_q[gi]) begin
            qcnt_q[gi] <= '0;
          end else if (qcnt_q[gi] != CNT_W'(QUAL_CYC)) begin
            qcnt_q[gi] <= qcnt_q[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_ev, wr_mask, wr_rd, wr_sp, wr_dc, wr_ser;
  logic ser_ok, ser_nak, zero_start, cal_start;
  logic [1:0] ser_code_q;

  assign wr_ev = WR && (ADDR == REG_EVENT);
  assign wr_mask = WR && (ADDR == REG_MASK);
  assign wr_rd = WR && (ADDR == REG_READING);
  assign wr_sp = WR && (ADDR == REG_SETPOINT);
  assign wr_dc = WR && (ADDR == REG_DEVCTL);
  assign wr_ser = WR && (ADDR == REG_SERCMD);
  // Serial actions are locked out while the controller owns the port
  assign ser_nak = wr_ser && gate_f;
  assign ser_ok = wr_ser && !gate_f;
  assign zero_start = cmd_q[IN_ZERO] || (ser_ok && WDATA[1:0] == SER_ZERO);
  assign cal_start = cmd_q[IN_TUNE] || (ser_ok && WDATA[1:0] != SER_ZERO);

  // Last serial command code, kept for readback
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ser_code_q <= SER_CAL;
    end else if (wr_ser) begin
      ser_code_q <= WDATA[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Events, mask and interrupt
  // ----------------------------------------------------------------
  logic [EV_W-1:0] ev_q, mask_q, ev_set, ev_clr;

  assign ev_set = {ser_nak, ser_ok, cmd_q};
  assign ev_clr = wr_ev ? WDATA[EV_W-1:0] : '0;

  // Set beats clear so a same-cycle event is never lost
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ev_q <= '0;
      mask_q <= MASK_RST;
      IRQ <= 1'b0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
      if (wr_mask) begin
        mask_q <= WDATA[EV_W-1:0];
      end
      IRQ <= |(ev_q & mask_q);
    end
  end

  // Sequencer request pulses
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SEQ_START <= 1'b0;
      SEQ_VENT <= 1'b0;
    end else begin
      SEQ_START <= cmd_q[IN_START];
      SEQ_VENT <= cmd_q[IN_STOP];
    end
  end

  // ----------------------------------------------------------------
  // Instrument status
  // ----------------------------------------------------------------
  // Not ready from reset until firmware declares the system running
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FIL_FAULT <= 1'b0;
      NOT_READY <= 1'b1;
      READY <= 1'b0;
    end else if (wr_dc) begin
      FIL_FAULT <= WDATA[DC_FIL];
      NOT_READY <= WDATA[DC_NRDY];
      READY <= !WDATA[DC_NRDY];
    end
  end

  // Busy flags; a new start wins over a done in the same cycle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ZEROING <= 1'b0;
      CALIBRATING <= 1'b0;
      CAL_OK <= 1'b0;
    end else begin
      ZEROING <= zero_start || (ZEROING && !(wr_dc && WDATA[DC_ZDONE]));
      CALIBRATING <= cal_start || (CALIBRATING && !(wr_dc && WDATA[DC_CDONE]));
      if (cal_start) begin
        CAL_OK <= 1'b0;
      end else if (wr_dc && WDATA[DC_CDONE] && CALIBRATING) begin
        CAL_OK <= WDATA[DC_CPASS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reading, range exponent and reject compare
  // ----------------------------------------------------------------
  ldp_bcd2_s mant_q;
  logic [6:0] exp_q;
  logic [15:0] sp_q;
  logic pend_q, latch;

  // Auto ranging only rescales on a fresh reading, so no hunting
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mant_q <= '0;
      exp_q <= EXP_RST;
    end else if (auto_f) begin
      if (wr_rd) begin
        if (WDATA[RD_OVER] && exp_q != EXP_MAX) begin
          exp_q <= exp_q + 7'd1;
          mant_q <= WDATA[7:0];
        end else if (WDATA[7:4] == 4'h0 && WDATA[3:0] != 4'h0 && exp_q != 7'd0) begin
          exp_q <= exp_q - 7'd1;
          mant_q <= {WDATA[3:0], 4'h0};
        end else begin
          mant_q <= WDATA[7:0];
        end
      end
    end else begin
      if (wr_rd) begin
        mant_q <= WDATA[7:0];
      end
      if (cmd_q[IN_DOWN] && exp_q != 7'd0) begin
        exp_q <= exp_q - 7'd1;
      end else if (cmd_q[IN_UP] && exp_q != EXP_MAX) begin
        exp_q <= exp_q + 7'd1;
      end
    end
  end

  // Set point and over-limit flag
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sp_q <= SETPOINT_RST;
      REJECT <= 1'b0;
    end else begin
      if (wr_sp) begin
        sp_q <= {1'b0, WDATA[14:0]};
      end
      REJECT <= (exp_q > sp_q[14:8])
                || (exp_q == sp_q[14:8] && mant_q > sp_q[7:0]);
    end
  end

  // New value waiting for the next strobe frame; set beats clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pend_q <= 1'b1;
    end else begin
      pend_q <= (pend_q && !latch) || wr_rd || cmd_q[IN_DOWN] || cmd_q[IN_UP];
    end
  end

  // ----------------------------------------------------------------
  // Update strobe and digit outputs
  // ----------------------------------------------------------------
  ldp_strobe_e st_q;
  logic [CNT_W-1:0] scnt_q;

  assign latch = (st_q == ST_HIGH) && (scnt_q == CNT_W'(STROBE_HI - 1));

  // Digits move only on the falling edge, then hold for a low period
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_HOLD;
      scnt_q <= '0;
      UPDATE_STROBE <= 1'b0;
      MANT <= '0;
      EXPN <= '0;
    end else begin
      case (st_q)
        ST_HOLD: begin
          scnt_q <= scnt_q + 1'b1;
          if (scnt_q == CNT_W'(STROBE_LO - 1)) begin
            st_q <= ST_WAIT;
            scnt_q <= '0;
          end
        end
        ST_WAIT: begin
          if (pend_q) begin
            st_q <= ST_HIGH;
            UPDATE_STROBE <= 1'b1;
          end
        end
        ST_HIGH: begin
          scnt_q <= scnt_q + 1'b1;
          if (latch) begin
            st_q <= ST_HOLD;
            scnt_q <= '0;
            UPDATE_STROBE <= 1'b0;
            MANT <= mant_q;
            EXPN <= ldp_to_bcd(exp_q);
          end
        end
        default: begin
          st_q <= ST_HOLD;
          scnt_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        REG_EVENT: RDATA <= {24'h0, ev_q};
        REG_MASK: RDATA <= {24'h0, mask_q};
        REG_READING: RDATA <= {17'h0, exp_q, mant_q};
        REG_SETPOINT: RDATA <= {16'h0, sp_q};
        REG_DEVCTL: RDATA <= {30'h0, NOT_READY, FIL_FAULT};
        REG_DEVSTAT: RDATA <= {25'h0, UPDATE_STROBE, REJECT, CAL_OK, CALIBRATING,
                               ZEROING, auto_f, gate_f};
        REG_SERCMD: RDATA <= {30'h0, ser_code_q};
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_start;
    cmd_q[IN_START] |=> SEQ_START ##1 !SEQ_START;
  endproperty
  a_start: assert property (p_start) else $error("start request not one pulse");

  property p_vent;
    $rose(SEQ_VENT) |-> $past(filt_q[IN_STOP], 2) && $past(gate_f, 2);
  endproperty
  a_vent: assert property (p_vent) else $error("vent without gated stop");

  property p_gate;
    !gate_f |=> (cmd_q == '0);
  endproperty
  a_gate: assert property (p_gate) else $error("command taken without gate");

  property p_once;
    (cmd_q != '0) |=> ((cmd_q & $past(cmd_q)) == '0);
  endproperty
  a_once: assert property (p_once) else $error("command taken twice");

  property p_zero;
    zero_start |=> ZEROING && ev_q != '0;
  endproperty
  a_zero: assert property (p_zero) else $error("zeroing not flagged");

  property p_cal;
    cal_start |=> CALIBRATING && !CAL_OK;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration start wrong");

  property p_calok;
    $rose(CAL_OK) |-> $past(wr_dc && WDATA[DC_CPASS] && CALIBRATING);
  endproperty
  a_calok: assert property (p_calok) else $error("cal ok without pass");

  property p_ready;
    READY == !NOT_READY;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not inverse");

  property p_down;
    cmd_q[IN_DOWN] && !auto_f && exp_q != 7'd0 |=> exp_q == $past(exp_q) - 7'd1;
  endproperty
  a_down: assert property (p_down) else $error("scale down missed");

  property p_up;
    cmd_q[IN_UP] && !cmd_q[IN_DOWN] && !auto_f && exp_q != EXP_MAX
      |=> exp_q == $past(exp_q) + 7'd1;
  endproperty
  a_up: assert property (p_up) else $error("scale up missed");

  property p_hold;
    !UPDATE_STROBE && !$past(UPDATE_STROBE) |-> $stable(MANT) && $stable(EXPN);
  endproperty
  a_hold: assert property (p_hold) else $error("digits moved while low");

  property p_nak;
    wr_ser && gate_f && !cmd_q[IN_ZERO] && !cmd_q[IN_TUNE]
      |=> ev_q[EV_SER_NAK] && $stable(ZEROING) && $stable(CALIBRATING);
  endproperty
  a_nak: assert property (p_nak) else $error("serial command not refused");

  property p_digit;
    EXPN.hi <= 4'h9 && EXPN.lo <= 4'h9;
  endproperty
  a_digit: assert property (p_digit) else $error("exponent not BCD");

  c_start: cover property (cmd_q[IN_START] ##1 SEQ_START);
  c_fall: cover property ($fell(UPDATE_STROBE));
  c_nak: cover property (ser_nak);
  c_auto: cover property (auto_f && wr_rd && WDATA[RD_OVER]);

endmodule // ldp_plc_port

// file: testbench/ldp_plc_model.sv
`timescale 1ns/1ns

module ldp_plc_model (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic [7:0] len,
  // Momentary lines towards the instrument
  output logic [5:0] pins
);
  logic [5:0] pins_q = 6'h00;
  logic [7:0] cnt_q = 8'h00;

  // ----------------------------------------------------------------
  // Momentary pulse generator
  // ----------------------------------------------------------------
  // One line high for len cycles, then driven low again; never a held level
  always_ff @(posedge clk) begin
    if (go) begin
      pins_q <= 6'h01 << sel;
      cnt_q <= len;
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      pins_q <= 6'h00;
      cnt_q <= 8'h00;
    end
  end

  assign pins = pins_q;
endmodule  // ldp_plc_model

// file: testbench/testbench.sv
`timescale 1ns/1ns

module testbench;
  import ldp_pkg::*;

  // Short counts keep the run small
  localparam int QC = 8;
  localparam int SC = 4;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic gate = 1'b0;
  logic self_scale = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] len = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [5:0] pins;
  logic reject, fil_fault, not_ready, ready, cal_ok, zeroing, calibrating;
  logic strobe, seq_start, seq_vent, irq;
  ldp_bcd2_s mant, expn;
  int n_mismatch = 0;
  int n_tests = 0;
  int m_exp = 0;
  int n_start = 0;
  int n_vent = 0;
  int i, n;

  always #5 clk = ~clk;

  ldp_plc_model ldp_plc_model_inst (.clk(clk), .go(go), .sel(sel), .len(len), .pins(pins));

  ldp_plc_port #(.QUAL_CYC(QC), .STROBE_HI(SC), .STROBE_LO(SC)) ldp_plc_port_inst (
    .REF_CLK(clk), .RST(rst), .START(pins[IN_START]), .STOP(pins[IN_STOP]),
    .GATE(gate), .ZERO(pins[IN_ZERO]), .TUNE_REQ(pins[IN_TUNE]),
    .SCALE_DN(pins[IN_DOWN]), .SCALE_UP(pins[IN_UP]), .SELF_SCALE(self_scale),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .REJECT(reject), .FIL_FAULT(fil_fault), .NOT_READY(not_ready), .READY(ready),
    .CAL_OK(cal_ok), .ZEROING(zeroing), .CALIBRATING(calibrating),
    .UPDATE_STROBE(strobe), .MANT(mant), .EXPN(expn),
    .SEQ_START(seq_start), .SEQ_VENT(seq_vent), .IRQ(irq));

  // Sequencer pulses are one cycle wide, so count them as they pass
  always @(posedge clk) begin
    if (seq_start === 1'b1) n_start++;
    if (seq_vent === 1'b1) n_vent++;
  end

  // ----------------------------------------------------------------
  // Comparison, bus and pulse tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_pin(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    chk_reg(nm, e, d);
  endtask

  // Pin commands need sync, filter and qualification before they act
  task automatic pulse(input int s, input int l);
    @(posedge clk);
    go <= 1'b1;
    sel <= 3'(s);
    len <= 8'(l);
    @(posedge clk);
    go <= 1'b0;
    repeat (l + 16) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction

  task automatic test_done;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well beyond the expected several hundred cycles
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(48));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk_pin("not_ready", 1'b1, not_ready);
    chk_pin("ready", 1'b0, ready);
    rd_reg(REG_SETPOINT, 32'h6399, "setpoint");
    rd_reg(REG_MASK, 32'h0, "mask");
    rd_reg(8'h40, 32'h0, "unmapped");
    // Status lines follow the device state
    wr_reg(REG_DEVCTL, 32'h3);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("fil_fault", 1'b1, fil_fault);
    chk_pin("ready", 1'b0, ready);
    wr_reg(REG_DEVCTL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("not_ready", 1'b0, not_ready);
    chk_pin("ready", 1'b1, ready);
    // Ungated and too-short pulses must do nothing
    pulse(IN_START, 20);
    @(posedge clk);
    gate <= 1'b1;
    pulse(IN_START, 4);
    chk_reg("start count", 32'(0), 32'(n_start));
    rd_reg(REG_EVENT, 32'h0, "event");
    wr_reg(REG_MASK, 32'h03);
    pulse(IN_START, 20);
    chk_reg("start count", 32'(1), 32'(n_start));
    rd_reg(REG_EVENT, 32'h01, "event");
    chk_pin("irq", 1'b1, irq);
    wr_reg(REG_EVENT, 32'h01);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("irq", 1'b0, irq);
    pulse(IN_STOP, 20);
    chk_reg("vent count", 32'(1), 32'(n_vent));
    rd_reg(REG_EVENT, 32'h02, "event");
    // Zeroing and calibration status
    pulse(IN_ZERO, 20);
    chk_pin("zeroing", 1'b1, zeroing);
    wr_reg(REG_DEVCTL, 32'h04);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("zeroing", 1'b0, zeroing);
    pulse(IN_TUNE, 20);
    chk_pin("calibrating", 1'b1, calibrating);
    wr_reg(REG_DEVCTL, 32'h18);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("calibrating", 1'b0, calibrating);
    chk_pin("cal_ok", 1'b1, cal_ok);
    pulse(IN_TUNE, 20);
    chk_pin("cal_ok", 1'b0, cal_ok);
    wr_reg(REG_DEVCTL, 32'h08);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("cal_ok", 1'b0, cal_ok);
    // Manual ranging, clamped at the bottom, random number of raises
    pulse(IN_DOWN, 20);
    n = $urandom_range(5, 2);
    for (i = 0; i < n; i++) begin
      pulse(IN_UP, 20);
      m_exp++;
    end
    pulse(IN_DOWN, 20);
    m_exp--;
    rd_reg(REG_READING, 32'(m_exp) << 8, "exponent");
    // Digits appear at the strobe fall and hold while it stays low
    wr_reg(REG_READING, 32'h47);
    // Sample mid-cycle so the strobe is never read at its launching edge
    for (i = 0; i < 30 && strobe !== 1'b1; i++) @(negedge clk);
    chk_pin("strobe", 1'b1, strobe);
    chk_reg("mantissa", 32'h00, 32'(mant));
    for (i = 0; i < 30 && strobe !== 1'b0; i++) @(negedge clk);
    chk_pin("strobe", 1'b0, strobe);
    chk_reg("mantissa", 32'h47, 32'(mant));
    chk_reg("exponent digits", 32'(bcd(m_exp)), 32'(expn));
    repeat (2) @(posedge clk);
    #1;
    chk_reg("mantissa", 32'h47, 32'(mant));
    // Over-limit against the set point
    wr_reg(REG_SETPOINT, (32'(m_exp) << 8) | 32'h50);
    wr_reg(REG_READING, 32'h51);
    repeat (3) @(posedge clk);
    #1;
    chk_pin("reject", 1'b1, reject);
    wr_reg(REG_READING, 32'h47);
    repeat (3) @(posedge clk);
    #1;
    chk_pin("reject", 1'b0, reject);
    // Serial maintenance commands are refused while gated
    wr_reg(REG_EVENT, 32'hff);
    for (i = 0; i < 4; i++) begin
      wr_reg(REG_SERCMD, 32'(i));
      rd_reg(REG_EVENT, 32'h80, "event");
      wr_reg(REG_EVENT, 32'hff);
    end
    chk_pin("zeroing", 1'b0, zeroing);
    chk_pin("calibrating", 1'b0, calibrating);
    gate <= 1'b0;
    repeat (6) @(posedge clk);
    wr_reg(REG_SERCMD, 32'h3);
    rd_reg(REG_EVENT, 32'h40, "event");
    chk_pin("zeroing", 1'b1, zeroing);
    rd_reg(REG_SERCMD, 32'h3, "serial code");
    wr_reg(REG_DEVCTL, 32'h04);
    // Focus peak ungated starts a calibration
    wr_reg(REG_SERCMD, 32'h1);
    @(posedge clk);
    #1;
    chk_pin("calibrating", 1'b1, calibrating);
    chk_pin("zeroing", 1'b0, zeroing);
    wr_reg(REG_DEVCTL, 32'h08);
    repeat (2) @(posedge clk);
    #1;
    chk_pin("calibrating", 1'b0, calibrating);
    @(posedge clk);
    // Automatic ranging: over-range raises, scale pulses ignored
    gate <= 1'b1;
    self_scale <= 1'b1;
    repeat (6) @(posedge clk);
    wr_reg(REG_READING, 32'h10012);
    m_exp++;
    rd_reg(REG_READING, (32'(m_exp) << 8) | 32'h12, "auto reading");
    pulse(IN_UP, 20);
    rd_reg(REG_READING, (32'(m_exp) << 8) | 32'h12, "auto reading");
    // Small reading with a zero high digit steps the exponent down
    wr_reg(REG_READING, 32'h05);
    m_exp--;
    rd_reg(REG_READING, (32'(m_exp) << 8) | 32'h50, "auto reading");
    test_done();
  end
endmodule  // testbench
